// *** core/leqt_pkg.sv ***
// Constants, field layouts and types for the logic equation timer engine
package leqt_pkg;
    // Timing: the processing interval is a quarter of a power-system cycle
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned LINE_FREQ_HZ  = 60;
    localparam int unsigned QTR_CYC =
        (1_000_000_000 / CLK_PERIOD_NS) / (4 * LINE_FREQ_HZ);
    localparam int unsigned ICW = 21;

    // Settings memory geometry: {group, equation, slot}
    localparam int unsigned MEM_AW    = 10;
    localparam int unsigned MEM_DW    = 22;
    localparam int unsigned MEM_DEPTH = 1024;
    localparam int unsigned REG_AW    = 13;

    // Equation numbers and walk steps
    localparam logic [4:0] EQ_EVENT = 5'h10;
    localparam logic [4:0] EQ_OUT   = 5'h11;
    localparam logic [4:0] EQ_LAST  = 5'h11;
    localparam logic [4:0] EQ_PU    = 5'h12;
    localparam logic [4:0] EQ_DO    = 5'h13;
    localparam logic [4:0] STEP_HDR = 5'h0F;
    localparam logic [4:0] STEP_PU  = 5'h10;
    localparam logic [4:0] STEP_DO  = 5'h11;

    // Resource limits and delay ranges in quarter-cycle steps
    localparam logic [8:0]  ELEM_LIMIT    = 9'h080;
    localparam logic [8:0]  EDGE_LIMIT    = 9'h016;
    localparam logic [21:0] LONG_DLY_MAX  = 22'h3D08FC;
    localparam logic [21:0] SHORT_DLY_MAX = 22'h00FA00;
    localparam logic [3:0]  LONG_UNITS    = 4'h6;

    // Register byte addresses; the memory window sits below REG_CTRL
    localparam logic [12:0] REG_CTRL   = 13'h1000;
    localparam logic [12:0] REG_STATUS = 13'h1004;
    localparam logic [12:0] REG_AVAIL  = 13'h1008;
    localparam int unsigned CTRL_SAVE    = 0;
    localparam int unsigned STAT_REJECT  = 2;
    localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;

    // Status bit map seen by the equations
    localparam int unsigned SB_OPEN = 19;

    // One operand slot of an equation
    typedef struct packed {
        logic       used;
        logic       inv;
        logic       rise;
        logic       fall;
        logic       or_join;
        logic [4:0] spare;
        logic [5:0] src;
    } leqt_slot_t;

    // Header word of an equation
    typedef enum logic [1:0] {
        MODE_EMPTY = 2'h0,
        MODE_EXPR  = 2'h1,
        MODE_ONE   = 2'h2,
        MODE_ZERO  = 2'h3
    } leqt_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHECK,
        ST_EVAL
    } leqt_state_t;
endpackage : leqt_pkg

// *** core/leqt_store.sv ***
// Settings memory with one write port and two registered read ports
`timescale 1ns/10ps
module leqt_store
    import leqt_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [MEM_AW-1:0] wr_addr,
    input  wire logic [MEM_DW-1:0] wr_data,
    // Engine read port
    input  wire logic [MEM_AW-1:0] eng_addr,
    output logic      [MEM_DW-1:0] eng_q,
    // Register read port
    input  wire logic              bus_rd,
    input  wire logic              bus_sel_mem,
    input  wire logic [MEM_AW-1:0] bus_addr,
    input  wire logic [31:0]       bus_alt,
    output logic      [31:0]       bus_q
);
    logic [MEM_DW-1:0] mem [MEM_DEPTH];

    // Array has no reset so it maps onto block memory
    always_ff @(posedge ref_clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Engine read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eng_q <= '0;
        end else if (ce) begin
            eng_q <= mem[eng_addr];
        end
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_q <= RESET_VALUE;
        end else if (ce) begin
            if (!bus_rd) begin
                bus_q <= RESET_VALUE;
            end else if (bus_sel_mem) begin
                bus_q <= {10'h000, mem[bus_addr]};
            end else begin
                bus_q <= bus_alt;
            end
        end
    end
endmodule : leqt_store

// *** core/leqt_engine.sv ***
// Logic equation engine with sixteen variable timers and report trigger
//
// How it works
// [R1] Edge operators act on one bit only
// [R2] Rising edge gives one interval pulse
// [R3] Falling edge gives one interval pulse
// [R4] Trigger rise starts report unless capture busy
// [R5] Sixteen units: equation, variable, timer output
// [R6] Units one to six: long delay range
// [R7] Units seven to sixteen: short delay range
// [R8] Separate pickup and dropout, same range
// [R9] Timer asserts after input true pickup time
// [R10] Timer holds for dropout after input falls
// [R11] Open/close command bit set one interval
// [R12] Variable may read its own previous value
// [R13] Change or switch clears variables and timers
// [R14] Delays reload before timing resumes
// [R15] Software gives every equation a value
// [R16] Constant equations evaluate to constant
// [R17] At most fifteen operands per equation
// [R18] Group limits: 128 elements, 22 edges
// [R19] Constant equation counts as one element
// [R20] Report remaining elements and edges after save
// [R21] Order: edge, invert, AND, OR
// [R22] One pass per quarter cycle, bits held
// [R23] Previous bit values cleared at reset
`timescale 1ns/10ps
module leqt_engine
    import leqt_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = QTR_CYC
) (
    // Clock, reset and freeze
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Register port
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Status bits from elements, inputs and commands
    input  wire logic [15:0]       element_bits,
    input  wire logic              opto_input_one,
    input  wire logic              opto_input_two,
    input  wire logic              underfreq_timed_flag,
    input  wire logic              open_cmd_req,
    input  wire logic              close_cmd_req,
    input  wire logic              group_select_two,
    input  wire logic              report_busy,
    // Results
    output logic      [15:0]       logic_variable_out,
    output logic      [15:0]       logic_timer_out,
    output logic                   event_report_start,
    output logic                   output_contact_one
);
    localparam logic [ICW-1:0] IVAL_LAST = ICW'(INTERVAL_CYC - 1);

    leqt_state_t       state_reg, state_next;
    logic [ICW-1:0]    ival_reg;
    logic              tick_reg, grp_reg, armed_reg, reject_reg, bad_reg;
    logic [4:0]        eq_reg, step_reg, d_eq_reg, d_step_reg;
    logic              d_vld_reg, d_chk_reg;
    logic [MEM_DW-1:0] eng_q;
    logic [MEM_AW-1:0] eng_addr, bus_idx;
    logic [20:0]       snap_reg;
    logic              oc_pend_reg, cc_pend_reg;
    logic [63:0]       cur, prev_reg;
    logic [15:0]       sv_reg, svt_reg;
    logic [21:0]       cnt_reg [16];
    logic [21:0]       pu_reg;
    leqt_mode_t        mode_reg, hmode;
    logic              term_reg, sum_reg, started_reg, er_prev_reg;
    logic [8:0]        elem_reg, edge_reg, elem_next, edge_next;
    logic [7:0]        elem_left_reg, edge_left_reg;
    logic [31:0]       bus_alt;

    // Register decode
    logic wr_mem, dly_word, long_unit, dly_ok, mem_we, wr_active;
    logic save_cmd, stat_clr, grp_switch, clr;
    assign bus_idx   = reg_addr[MEM_AW+1:2];
    assign wr_mem    = reg_wr && !reg_addr[12];
    assign dly_word  = bus_idx[8:4] == EQ_PU || bus_idx[8:4] == EQ_DO;
    assign long_unit = bus_idx[3:0] < LONG_UNITS;
    // Delay range is checked per unit; pickup and dropout share it
    assign dly_ok    = !dly_word || (reg_wdata[31:22] == 10'h000 &&
                       reg_wdata[21:0] <= (long_unit ? LONG_DLY_MAX
                                                     : SHORT_DLY_MAX)); // R6 R7 R8
    assign mem_we    = wr_mem && dly_ok;
    assign wr_active = mem_we && bus_idx[9] == grp_reg;
    assign save_cmd  = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SAVE];
    assign stat_clr  = reg_wr && reg_addr == REG_STATUS
                       && reg_wdata[STAT_REJECT];
    assign grp_switch = group_select_two != grp_reg;
    // A saved change or a group switch clears all unit timing state
    assign clr       = save_cmd || grp_switch; // R13

    // Read data for the registers outside the memory window
    assign bus_alt = (reg_addr == REG_STATUS) ?
                     {28'h0000000, bad_reg, reject_reg,
                      state_reg != ST_IDLE, armed_reg} :
                     (reg_addr == REG_AVAIL) ?
                     {16'h0000, edge_left_reg, elem_left_reg} : // R20
                     (reg_addr == REG_CTRL) ?
                     {30'h00000000, grp_reg, 1'b0} : 32'h00000000;

    leqt_store u_store (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .ce          (ce),
        .wr_en       (mem_we),
        .wr_addr     (bus_idx),
        .wr_data     (reg_wdata[MEM_DW-1:0]),
        .eng_addr    (eng_addr),
        .eng_q       (eng_q),
        .bus_rd      (reg_rd),
        .bus_sel_mem (!reg_addr[12]),
        .bus_addr    (bus_idx),
        .bus_alt     (bus_alt),
        .bus_q       (reg_rdata)
    );

    // Interval timer and walk sequencing
    logic is_walk, last_step, last_issue, pass_start;
    assign is_walk    = state_reg != ST_IDLE;
    assign last_step  = step_reg == (state_reg == ST_CHECK ? STEP_HDR
                                                           : STEP_DO);
    assign last_issue = is_walk && last_step && eq_reg == EQ_LAST;
    assign pass_start = tick_reg && state_reg == ST_IDLE && armed_reg && !clr;
    // Pickup and dropout words follow the slots of each variable
    assign eng_addr   = (step_reg < STEP_PU) ?
                        {grp_reg, eq_reg, step_reg[3:0]} :
                        {grp_reg, (step_reg == STEP_PU) ? EQ_PU : EQ_DO,
                         eq_reg[3:0]}; // R14

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (clr) begin
                    state_next = ST_CHECK;
                end else if (pass_start) begin
                    state_next = ST_EVAL; // R22
                end
            end
            ST_CHECK, ST_EVAL: begin
                if (clr) begin
                    state_next = ST_CHECK;
                end else if (last_issue) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Walk counters and the one-cycle memory pipeline behind them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            eq_reg    <= 5'h00;
            step_reg  <= 5'h00;
            d_vld_reg <= 1'b0;
            d_chk_reg <= 1'b0;
            d_eq_reg  <= 5'h00;
            d_step_reg <= 5'h00;
            ival_reg  <= '0;
            tick_reg  <= 1'b0;
            grp_reg   <= 1'b0;
        end else if (ce) begin
            state_reg  <= state_next;
            d_vld_reg  <= is_walk && !clr;
            d_chk_reg  <= state_reg == ST_CHECK;
            d_eq_reg   <= eq_reg;
            d_step_reg <= step_reg;
            grp_reg    <= group_select_two;
            tick_reg   <= ival_reg == IVAL_LAST;
            ival_reg   <= (ival_reg == IVAL_LAST) ? '0 : ival_reg + 1'b1;
            if (clr || !is_walk || last_issue) begin
                eq_reg   <= 5'h00;
                step_reg <= 5'h00;
            end else if (last_step) begin
                eq_reg   <= eq_reg + 5'h01;
                step_reg <= 5'h00;
            end else begin
                step_reg <= step_reg + 5'h01;
            end
        end
    end

    // Inputs and commands are frozen for a whole pass
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            snap_reg    <= '0;
            oc_pend_reg <= 1'b0;
            cc_pend_reg <= 1'b0;
        end else if (ce) begin
            // A request in the snapshot cycle waits for the next pass
            oc_pend_reg <= open_cmd_req || (oc_pend_reg && !pass_start);
            cc_pend_reg <= close_cmd_req || (cc_pend_reg && !pass_start);
            if (pass_start) begin
                snap_reg <= {cc_pend_reg, oc_pend_reg, underfreq_timed_flag,
                             opto_input_two, opto_input_one,
                             element_bits}; // R11 R22
            end
        end
    end

    assign cur = {8'h00, svt_reg, sv_reg, 3'h0, snap_reg};

    // Operand decode: edge first, then inversion, then AND, then OR
    leqt_slot_t slot;
    logic cur_bit, prv_bit, edge_bit, lit, is_slot, new_term, result;
    logic fin, pass_end, chk_hdr, chk_end;
    logic [3:0] u;
    assign slot     = leqt_slot_t'(eng_q[15:0]);
    assign hmode    = leqt_mode_t'(eng_q[1:0]);
    assign cur_bit  = cur[slot.src];
    assign prv_bit  = prev_reg[slot.src];
    // The format carries one source per slot, so no edge on a group
    assign edge_bit = slot.rise ? (cur_bit && !prv_bit) :
                      slot.fall ? (!cur_bit && prv_bit) : cur_bit; // R1 R2 R3
    assign lit      = edge_bit ^ slot.inv; // R21
    assign is_slot  = d_vld_reg && d_step_reg < STEP_HDR && slot.used; // R17
    assign new_term = !started_reg || slot.or_join;
    assign result   = (mode_reg == MODE_ONE) ||
                      (mode_reg == MODE_EXPR &&
                       (sum_reg || (started_reg && term_reg))); // R16 R21
    assign fin      = d_vld_reg && !d_chk_reg && d_step_reg == STEP_DO;
    assign pass_end = fin && d_eq_reg == EQ_LAST;
    assign chk_hdr  = d_vld_reg && d_chk_reg && d_step_reg == STEP_HDR;
    assign chk_end  = chk_hdr && d_eq_reg == EQ_LAST;
    assign u        = d_eq_reg[3:0];

    // Product and sum accumulators, reset at each equation end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            term_reg    <= 1'b0;
            sum_reg     <= 1'b0;
            started_reg <= 1'b0;
            mode_reg    <= MODE_EMPTY;
            pu_reg      <= '0;
        end else if (ce) begin
            if (clr || fin || chk_hdr) begin
                term_reg    <= 1'b0;
                sum_reg     <= 1'b0;
                started_reg <= 1'b0;
            end else if (is_slot) begin
                term_reg    <= new_term ? lit : (term_reg && lit);
                // A closed product joins the sum only if it came out true
                sum_reg     <= sum_reg || (started_reg && slot.or_join
                                           && term_reg); // R21
                started_reg <= 1'b1;
            end
            if (d_vld_reg && d_step_reg == STEP_HDR) begin
                mode_reg <= hmode;
            end
            if (d_vld_reg && d_step_reg == STEP_PU) begin
                pu_reg <= eng_q; // R14
            end
        end
    end

    // Shared pickup/dropout logic for the unit being finished
    logic [21:0] t_cnt, t_lim, t_cnt_next;
    logic        t_out, t_move, t_hit, t_out_next, unit_fin;
    assign unit_fin   = fin && !d_eq_reg[4];
    assign t_cnt      = cnt_reg[u];
    assign t_out      = svt_reg[u];
    assign t_lim      = result ? pu_reg : eng_q; // R8
    assign t_move     = result != t_out;
    assign t_hit      = t_cnt >= t_lim;
    assign t_out_next = (t_move && t_hit) ? result : t_out; // R9 R10
    assign t_cnt_next = (t_move && !t_hit) ? t_cnt + 22'h000001 : '0;

    // Per-unit interval counters
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_unit
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cnt_reg[gi] <= '0;
                end else if (ce) begin
                    if (clr) begin
                        cnt_reg[gi] <= '0; // R14
                    end else if (unit_fin && u == gi) begin
                        cnt_reg[gi] <= t_cnt_next; // R5
                    end
                end
            end
        end
    endgenerate

    // Variables, timers, trigger and contact; variable updates at the end
    // of its own equation, so a self reference sees last interval's value
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sv_reg      <= '0;
            svt_reg     <= '0;
            er_prev_reg <= 1'b0;
            prev_reg    <= '0; // R23
            event_report_start <= 1'b0;
            output_contact_one <= 1'b0;
        end else if (ce) begin
            event_report_start <= 1'b0;
            if (clr) begin
                sv_reg      <= '0; // R13
                svt_reg     <= '0;
                er_prev_reg <= 1'b0;
                prev_reg    <= '0;
                output_contact_one <= 1'b0;
            end else begin
                if (unit_fin) begin
                    sv_reg[u]  <= result; // R5 R12
                    svt_reg[u] <= t_out_next;
                end
                if (fin && d_eq_reg == EQ_EVENT) begin
                    er_prev_reg <= result;
                    event_report_start <= result && !er_prev_reg
                                          && !report_busy; // R4
                end
                if (fin && d_eq_reg == EQ_OUT) begin
                    output_contact_one <= result;
                end
                if (pass_end) begin
                    prev_reg <= cur; // R23
                end
            end
        end
    end

    // Resource check walk after save or group switch
    logic bad_next, ok_next;
    assign elem_next = elem_reg + {8'h00, is_slot && d_chk_reg}
                       + {8'h00, chk_hdr && (hmode == MODE_ONE
                                             || hmode == MODE_ZERO)}; // R19
    assign edge_next = edge_reg + {8'h00, is_slot && d_chk_reg
                                          && (slot.rise || slot.fall)};
    // Empty equations and double edges are refused as settings faults
    assign bad_next  = bad_reg || (is_slot && d_chk_reg && slot.rise
                                   && slot.fall)
                       || (chk_hdr && (hmode == MODE_EMPTY
                           || (hmode == MODE_EXPR && !started_reg))); // R15
    assign ok_next   = !bad_next && elem_next <= ELEM_LIMIT
                       && edge_next <= EDGE_LIMIT; // R18

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            elem_reg      <= '0;
            edge_reg      <= '0;
            bad_reg       <= 1'b0;
            armed_reg     <= 1'b0;
            reject_reg    <= 1'b0;
            elem_left_reg <= '0;
            edge_left_reg <= '0;
        end else if (ce) begin
            // Range faults are sticky; a new fault beats the clear
            reject_reg <= (wr_mem && !dly_ok)
                          || (reject_reg && !stat_clr); // R6 R7
            if (clr) begin
                elem_reg  <= '0;
                edge_reg  <= '0;
                bad_reg   <= 1'b0;
                armed_reg <= 1'b0;
            end else if (chk_end) begin
                armed_reg <= ok_next && !wr_active; // R17 R18
                bad_reg   <= !ok_next;
                elem_left_reg <= (elem_next > ELEM_LIMIT) ? 8'h00 :
                                 8'(ELEM_LIMIT - elem_next); // R20
                edge_left_reg <= (edge_next > EDGE_LIMIT) ? 8'h00 :
                                 8'(EDGE_LIMIT - edge_next);
            end else begin
                elem_reg <= elem_next;
                edge_reg <= edge_next;
                bad_reg  <= bad_next;
                if (wr_active) begin
                    armed_reg <= 1'b0;
                end
            end
        end
    end

    assign logic_variable_out = sv_reg;
    assign logic_timer_out    = svt_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_evt_single_cycle: assert property ( // R4
        event_report_start && ce |=> !event_report_start)
        else $error("report start lasted more than one cycle");
    a_evt_not_busy: assert property ( // R4
        $rose(event_report_start) |-> !$past(report_busy) && er_prev_reg)
        else $error("report started while capture busy");
    a_change_clears: assert property ( // R13
        ce && clr |=> sv_reg == 16'h0000 && svt_reg == 16'h0000
                      && !output_contact_one)
        else $error("variables not cleared on settings change");
    a_pickup_needs_in: assert property ( // R9
        (svt_reg & ~$past(svt_reg) & ~sv_reg) == 16'h0000)
        else $error("timer rose while its variable was low");
    a_dropout_needs_low: assert property ( // R10
        (~svt_reg & $past(svt_reg) & sv_reg) == 16'h0000)
        else $error("timer fell while its variable was high");
    a_short_range: assert property ( // R7
        ce && wr_mem && dly_word && !long_unit
        && reg_wdata[21:0] > SHORT_DLY_MAX |=> reject_reg)
        else $error("out of range delay not flagged");
    a_snap_per_pass: assert property ( // R11
        $changed(snap_reg) |-> $past(pass_start))
        else $error("status snapshot moved outside pass start");
    a_prev_at_end: assert property ( // R23
        $changed(prev_reg) |-> $past(pass_end) || $past(clr))
        else $error("edge history moved mid pass");
    a_arm_in_limits: assert property ( // R18
        $rose(armed_reg) |-> $past(elem_next) <= ELEM_LIMIT
                             && $past(edge_next) <= EDGE_LIMIT)
        else $error("group armed over its limits");
    a_const_one_out: assert property ( // R16
        ce && !clr && fin && d_eq_reg == EQ_OUT && mode_reg == MODE_ONE
        |=> output_contact_one)
        else $error("constant one equation not asserted");

    c_report: cover property (event_report_start);
    c_armed: cover property ($rose(armed_reg));
    c_timer: cover property ($rose(svt_reg[0]));
endmodule : leqt_engine

// *** verification/leqt_field.sv ***
// Far-side model: event report capture window
`timescale 1ns/10ps
module leqt_field
    import leqt_pkg::*;
#(
    parameter int unsigned BUSY_CYC = 4000
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Engine request and capture state
    input  wire logic       event_report_start,
    output logic            report_busy,
    output logic [7:0]      report_count
);
    logic [15:0] busy_cnt_reg;

    // A capture stays open for a fixed span; the engine must hold off
    assign report_busy = busy_cnt_reg != 16'h0000;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_reg <= 16'h0000;
            report_count <= 8'h00;
        end else if (event_report_start) begin
            busy_cnt_reg <= 16'(BUSY_CYC);
            report_count <= report_count + 8'h01;
        end else if (report_busy) begin
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
        end
    end
endmodule : leqt_field

// *** verification/tb_top.sv ***
// Self-checking bench for the logic equation engine
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
    import leqt_pkg::*;
    logic        ref_clk = 0, rst = 1, ce = 1, zero = 0;
    logic        reg_wr = 0, reg_rd = 0, opn = 0, grp = 0, busy, evs, cont;
    logic [12:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rdat, w;
    logic [15:0] elem = 0, vars, tims;
    logic [7:0]  nrep;
    int          fail_count = 0, num_checks = 0, e;
    // Slot 0 of each equation; zero means a constant equation
    localparam logic [15:0] SLOT0 [20] = '{0: 16'h8000, 1: 16'hA000,
        2: 16'h9000, 4: 16'h8013, 5: 16'hC000, 16: 16'hA000,
        17: 16'h8028, 18: 16'h0002, 19: 16'h0003, default: 16'h0000};
    // Rows: input, open command, {contact, timer 0, variables 5..0}
    localparam logic [9:0] ROWS [10] = '{10'h33B, 10'h209, 10'h2C9,
        10'h2C9, 10'h0EC, 10'h0E8, 10'h0E8, 10'h028, 10'h20B, 10'h02C};

    leqt_engine #(.INTERVAL_CYC(400)) i_leqt_engine (.ref_clk, .rst, .ce,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .element_bits(elem), .opto_input_one(zero), .opto_input_two(zero),
        .underfreq_timed_flag(zero), .open_cmd_req(opn),
        .close_cmd_req(zero), .group_select_two(grp), .report_busy(busy),
        .logic_variable_out(vars), .logic_timer_out(tims),
        .event_report_start(evs), .output_contact_one(cont));
    leqt_field i_leqt_field (.ref_clk, .rst, .event_report_start(evs),
        .report_busy(busy), .report_count(nrep));

    always #2 ref_clk = ~ref_clk;

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [12:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 rdat = reg_rdata;
    endtask : rd

    task automatic print_verdict;
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Watchdog, well beyond the expected length of the run
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1 `CHK("vars", 16'h0000, vars)
        // Words 0 to 319 (group 0, rows 0 to 19) are written since the store has no reset
        for (int i = 0; i < 320; i++) begin
            e = i / 16;
            w = (SLOT0[e] != 0) ? 32'h1 : (e == 3) ? 32'h2 : 32'h3;
            if (i % 16 == 0) w = 32'(SLOT0[e]);
            else if (i % 16 != 15 || e > 17) w = 32'h0;
            // Equation 5 is the sum of an inverted input and the open bit
            if (i == 81) w = 32'h8813;
            wr(13'(i * 4), w);
        end
        wr(REG_CTRL, 32'h1);
        wait (vars[3]);
        // Rows then change late in the interval, so each check sees a
        // whole pass, contact equation included
        repeat (260) @(posedge ref_clk);
        foreach (ROWS[k]) begin
            @(posedge ref_clk);
            elem[0] <= ROWS[k][9];
            opn     <= ROWS[k][8];
            @(posedge ref_clk);
            opn <= 1'b0;
            repeat (398) @(posedge ref_clk);
            #1 `CHK("outs", ROWS[k][7:0], {cont, tims[0], vars[5:0]})
        end
        `CHK("reports", 8'h01, nrep)
        rd(REG_AVAIL);
        `CHK("avail", 16'h136D, rdat[15:0])
        @(posedge ref_clk) grp <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 `CHK("cleared", 32'h0, {vars, tims})
        wr(13'h0498, 32'h0000FA01);
        rd(REG_STATUS);
        `CHK("reject", 1'b1, rdat[2])
        rd(13'h100C);
        `CHK("unmapped", 32'h0, rdat)
        print_verdict();
    end
endmodule : tb_top
